// ===== bench/fault_source_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_out_defs.svh"

module fault_source_model (
  input  wire logic                                  ref_clk,
  input  wire logic                                  faultLevel,
  input  wire timer_out_pkg::ch_pins_t [`NUM_CH-1:0] pins,
  output var  logic                                  breakFaultInput,
  output var  logic                                  shootThrough
);
  import timer_out_pkg::*;

  // ==========================================================
  // Fault pin and switch pair
  initial begin
    breakFaultInput = 1'b1;
    shootThrough    = 1'b0;
  end

  // Comparator output is registered on the timer clock; the gate must drop
  // before the following edge, which proves the clear does not wait for it
  always @(posedge ref_clk) begin
    breakFaultInput <= faultLevel;
  end

  // Both switches of a leg on at once would short the supply; valid for active-high polarity
  always @(posedge ref_clk) begin
    for (int i = 0; i < `NUM_CH; i++) begin
      if (pins[i].mainOe && pins[i].mainOut && pins[i].compOe && pins[i].compOut) begin
        shootThrough <= 1'b1;
      end
    end
  end
endmodule : fault_source_model

`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_out_defs.svh"

module tb_top;
  import timer_out_pkg::*;

  // ==========================================================
  // Signals
  logic                   ref_clk;
  logic                   arst_n;
  wb_req_t                wbReq;
  wb_rsp_t                wbRsp;
  logic [`NUM_CH-1:0]     pwmRef;
  logic                   updateEvent;
  logic                   breakFaultInput;
  logic                   clockMonitorFail;
  ch_pins_t [`NUM_CH-1:0] chPins;
  logic                   primaryOutputGate;
  logic                   faultLevel;
  logic                   shootThrough;
  int                     n_mismatch;
  int                     compares;
  int                     cnt;
  int                     off;
  logic [31:0]            rd;
  logic [7:0]             regAdr [5] = '{`OFS_PROTECT_LEVEL, `OFS_DMACFG, `OFS_DMABUF, `OFS_XCFG, 8'h80};
  logic [7:0]             dtSet  [4] = '{8'h05, 8'h81, 8'hC1, 8'hE0};
  int                     dtLen  [4] = '{5, 130, 264, 512};

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  timer_output_ctrl u_timer_output_ctrl (
    .ref_clk           (ref_clk),
    .arst_n            (arst_n),
    .wbReq             (wbReq),
    .wbRsp             (wbRsp),
    .pwmRef            (pwmRef),
    .updateEvent       (updateEvent),
    .breakFaultInput   (breakFaultInput),
    .clockMonitorFail  (clockMonitorFail),
    .chPins            (chPins),
    .primaryOutputGate (primaryOutputGate)
  );

  fault_source_model u_fault_source_model (
    .ref_clk         (ref_clk),
    .faultLevel      (faultLevel),
    .pins            (chPins),
    .breakFaultInput (breakFaultInput),
    .shootThrough    (shootThrough)
  );

  // ==========================================================
  // Tasks
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 20);
    rd = wbRsp.dat;
    if (n >= 20) n_mismatch++;
    wbReq <= '0;
    @(posedge ref_clk);
  endtask : wb_xfer

  // Pins are registered: let the launching edge land before looking
  task settle;
    repeat (3) @(posedge ref_clk);
  endtask : settle

  task pulse_update;
    @(posedge ref_clk) updateEvent <= 1'b1;
    @(posedge ref_clk) updateEvent <= 1'b0;
  endtask : pulse_update

  task do_reset;
    @(posedge ref_clk) arst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
  endtask : do_reset

  task end_sim;
    $display("Comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // ==========================================================
  // Tests
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    arst_n = 1'b0;
    wbReq = '0;
    pwmRef = 4'h1;
    updateEvent = 1'b0;
    clockMonitorFail = 1'b0;
    faultLevel = 1'b1;
    n_mismatch = 0;
    compares = 0;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 5; i++) begin
      wb_xfer(1'b0, regAdr[i], 32'h0);
      check("resetValue", rd, 32'h0000_0000);
    end
    wb_xfer(1'b1, `OFS_CHEN, 32'h0000_0001);
    wb_xfer(1'b1, `OFS_PROTECT_LEVEL, 32'h0000_8000);
    settle();
    check("gateSet", primaryOutputGate, 1'b1);
    check("ch0Drive", {chPins[0].mainOe, chPins[0].mainOut, chPins[0].compOe}, 3'h6);
    check("ch1Off", chPins[1].mainOe, 1'b0);
    faultLevel <= 1'b0;
    clockMonitorFail <= 1'b1;
    settle();
    check("brkDisabled", primaryOutputGate, 1'b1);
    faultLevel <= 1'b1;
    clockMonitorFail <= 1'b0;
    wb_xfer(1'b1, `OFS_PROTECT_LEVEL, 32'h0000_8800);
    settle();
    check("runOffInactive", {chPins[1].mainOe, chPins[1].mainOut}, 2'h2);
    wb_xfer(1'b1, `OFS_PROTECT_LEVEL, 32'h0000_9000);
    settle();
    check("lowActiveIdle", primaryOutputGate, 1'b1);
    // The pin moves at this edge; the gate flop cannot have clocked it in yet
    faultLevel <= 1'b0;
    @(posedge ref_clk);
    #1;
    check("asyncClear", primaryOutputGate, 1'b0);
    faultLevel <= 1'b1;
    @(posedge ref_clk);
    wb_xfer(1'b1, `OFS_PROTECT_LEVEL, 32'h0000_7000);
    settle();
    check("idleDisabled", chPins[0].mainOe, 1'b0);
    pulse_update();
    settle();
    check("autoBlocked", primaryOutputGate, 1'b0);
    faultLevel <= 1'b0;
    repeat (4) @(posedge ref_clk);
    pulse_update();
    settle();
    check("autoSet", primaryOutputGate, 1'b1);
    clockMonitorFail <= 1'b1;
    settle();
    check("clockFail", primaryOutputGate, 1'b0);
    clockMonitorFail <= 1'b0;
    wb_xfer(1'b1, `OFS_PROTECT_LEVEL, 32'h0000_0400);
    settle();
    check("idleDriven", chPins[0].mainOe, 1'b1);
    wb_xfer(1'b1, `OFS_XCFG, 32'h0000_0001);
    settle();
    check("outSelIdle", chPins[0].mainOe, 1'b1);
    wb_xfer(1'b1, `OFS_PROTECT_LEVEL, 32'h0000_0000);
    settle();
    check("outSelOff", chPins[0].mainOe, 1'b0);
    wb_xfer(1'b1, `OFS_DMACFG, 32'h0000_010D);
    wb_xfer(1'b1, `OFS_DMABUF, 32'h0000_1111);
    wb_xfer(1'b1, `OFS_DMABUF, 32'h0000_2222);
    wb_xfer(1'b0, `OFS_DMABUF, 32'h0);
    check("burstWrap", rd, 32'h0000_1111);
    wb_xfer(1'b0, 8'h38, 32'h0);
    check("burstStep", rd, 32'h0000_2222);
    wb_xfer(1'b1, `OFS_XCFG, 32'h0000_0003);
    wb_xfer(1'b1, 8'h34, 32'h0000_3333);
    wb_xfer(1'b0, 8'h34, 32'h0);
    check("cvNewValue", rd, 32'h0000_3333);
    wb_xfer(1'b1, `OFS_CHEN, 32'h0000_0005);
    for (int i = 0; i < 4; i++) begin
      wb_xfer(1'b1, `OFS_PROTECT_LEVEL, 32'h0000_8000 | 32'(dtSet[i]));
      pwmRef <= 4'h0;
      repeat (600) @(posedge ref_clk);
      pwmRef <= 4'h1;
      cnt = 0;
      do begin
        @(posedge ref_clk);
        cnt++;
      end while (chPins[0].mainOut !== 1'b1 && cnt < 900);
      if (i == 0) off = cnt - dtLen[0];
      check("deadTime", 32'(cnt - dtLen[i]), 32'(off));
    end
    check("shootThrough", shootThrough, 1'b0);
    faultLevel <= 1'b1;
    do_reset();
    wb_xfer(1'b1, `OFS_PROTECT_LEVEL, 32'h0000_1105);
    wb_xfer(1'b1, `OFS_PROTECT_LEVEL, 32'h0000_8FFF);
    wb_xfer(1'b0, `OFS_PROTECT_LEVEL, 32'h0);
    check("protectLock", rd, 32'h0000_9D05);
    settle();
    check("runOffDrive", chPins[0].mainOe, 1'b1);
    wb_xfer(1'b1, `OFS_CHMODE, 32'h0000_0001);
    settle();
    check("inputMode", chPins[0].mainOe, 1'b0);
    wb_xfer(1'b1, `OFS_CHMODE, 32'h0000_0000);
    wb_xfer(1'b1, `OFS_PROTECT_LEVEL, 32'h0000_8000);
    settle();
    check("runOffDisable", chPins[0].mainOe, 1'b0);
    end_sim();
  end
endmodule : tb_top

`default_nettype wire

// ===== pkg/timer_out_defs.svh
`ifndef TIMER_OUT_DEFS_SVH
`define TIMER_OUT_DEFS_SVH

// ==========================================================
// Register byte offsets
`define OFS_CTL0      8'h00
`define OFS_CTL1      8'h04
`define OFS_CHMODE    8'h18
`define OFS_CHEN      8'h20
`define OFS_CV0       8'h34
`define OFS_CV_LAST   8'h40
`define OFS_PROTECT_LEVEL      8'h44
`define OFS_DMACFG    8'h48
`define OFS_DMABUF    8'h4C
`define OFS_XCFG      8'hFC

// ==========================================================
// Field positions
`define CLOCK_DIVISION_FIELD_LSB     8
`define IDLE_LVL_LSB  8
`define GATE_BIT      15
`define AUTO_BIT      14
`define BRKPOL_BIT    13
`define BREAK_INPUTS_ENABLE_BIT     12
`define ROS_BIT       11
`define IOS_BIT       10
`define PROTECT_LEVEL_LSB      8
`define DT_LSB        0
`define BCNT_LSB      8
`define BSTART_LSB    0
`define IGNORE_BIT    1
`define OUTPUT_VALUE_SELECT_BIT    0

// ==========================================================
// Reset values and sizes
`define RESET_WORD    32'h0000_0000
`define NUM_CH        4
`define MODE_OUTPUT   2'h0
`define DT_BASE_LONG  10'h040
`define DT_BASE_SHORT 10'h020

`endif

// ===== pkg/timer_out_pkg.sv
package timer_out_pkg;

  // ==========================================================
  // Bus and pin carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic mainOut;
    logic mainOe;
    logic compOut;
    logic compOe;
  } ch_pins_t;

endpackage : timer_out_pkg

// ===== rtl/dead_time_gen.sv
`timescale 1ns/1ps
`default_nettype none

module dead_time_gen (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       tick,
  input  wire logic       refIn,
  input  wire logic [9:0] ticks,
  output var  logic       mainAct,
  output var  logic       compAct
);

  logic       refPrev;
  logic [9:0] count;

  // ==========================================================
  // Both sides drop at once, the new side rises after the gap
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      refPrev <= 1'b0;
      mainAct <= 1'b0;
      compAct <= 1'b0;
      count   <= 10'h000;
    end else if (refIn != refPrev) begin
      refPrev <= refIn;
      mainAct <= 1'b0;
      compAct <= 1'b0;
      count   <= ticks;
    end else if (count != 10'h000) begin
      if (tick) begin
        count <= count - 10'h001;
      end
    end else begin
      mainAct <= refPrev;
      compAct <= ~refPrev;
    end
  end

  a_dt_exclusive: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !(mainAct && compAct)) else $error("main and complementary both active");

  a_dt_gap: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (refIn != refPrev) && (ticks != 10'h000) |=> !mainAct && !compAct [*2])
    else $error("dead time gap missing");

endmodule : dead_time_gen

`default_nettype wire

// ===== rtl/timer_output_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_out_defs.svh"

module timer_output_ctrl (
  input  wire logic                                     ref_clk,
  input  wire logic                                     arst_n,
  input  wire timer_out_pkg::wb_req_t                   wbReq,
  output var  timer_out_pkg::wb_rsp_t                   wbRsp,
  input  wire logic [`NUM_CH-1:0]                       pwmRef,
  input  wire logic                                     updateEvent,
  input  wire logic                                     breakFaultInput,
  input  wire logic                                     clockMonitorFail,
  output var  timer_out_pkg::ch_pins_t [`NUM_CH-1:0]    chPins,
  output var  logic                                     primaryOutputGate
);
  import timer_out_pkg::*;

  // ==========================================================
  // Register state
  logic [1:0]              clockDivisionField;
  logic [2*`NUM_CH-1:0]    idleOutputLevel;
  logic [8*`NUM_CH-1:0]    chMode;
  logic [4*`NUM_CH-1:0]    chEnable;
  logic [15:0]             compareValue [`NUM_CH];
  logic                    autoOutputReenable;
  logic                    breakPolarity;
  logic                    breakInputsEnable;
  logic                    runOffState;
  logic                    idleOffState;
  logic [1:0]              protectLevel;
  logic                    protectWritten;
  logic [7:0]              deadTimeSetting;
  logic [4:0]              burstCount;
  logic [4:0]              burstStartAddress;
  logic [4:0]              burstIndex;
  logic                    redundantWriteIgnore;
  logic                    outputValueSelect;

  // ==========================================================
  // Bus decode
  logic        reqNew;
  logic        commit;
  logic [7:0]  burstSum;
  logic [7:0]  effAdr;
  logic [7:0]  cvOff;
  logic [1:0]  cvIdx;
  logic        cvHit;
  logic        mapped;
  logic [31:0] readData;
  logic [31:0] selMask;
  logic [31:0] merged;
  logic        wrStrobe;
  logic        wrCtl0;
  logic        wrCtl1;
  logic        wrMode;
  logic        wrEn;
  logic        wrCv;
  logic        wrProt;
  logic        wrDmaCfg;
  logic        wrXcfg;
  logic        bufAccess;
  logic        lockOne;
  logic        lockTwo;
  logic        lockThree;

  assign reqNew    = wbReq.cyc && wbReq.stb && !wbRsp.ack;
  assign commit    = wbReq.cyc && wbReq.stb && wbRsp.ack;
  assign bufAccess = wbReq.adr == `OFS_DMABUF;
  assign burstSum  = {3'h0, burstStartAddress} + {3'h0, burstIndex};
  assign effAdr    = bufAccess ? {burstSum[5:0], 2'h0} : wbReq.adr;
  assign cvOff     = effAdr - `OFS_CV0;
  assign cvIdx     = cvOff[3:2];
  assign cvHit     = (effAdr >= `OFS_CV0) && (effAdr <= `OFS_CV_LAST) && (effAdr[1:0] == 2'h0);
  assign selMask   = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}}, {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
  assign merged    = (readData & ~selMask) | (wbReq.dat & selMask);
  assign wrStrobe  = commit && wbReq.we && mapped;
  assign wrCtl0    = wrStrobe && (effAdr == `OFS_CTL0);
  assign wrCtl1    = wrStrobe && (effAdr == `OFS_CTL1);
  assign wrMode    = wrStrobe && (effAdr == `OFS_CHMODE);
  assign wrEn      = wrStrobe && (effAdr == `OFS_CHEN);
  assign wrCv      = wrStrobe && cvHit;
  assign wrProt    = wrStrobe && (effAdr == `OFS_PROTECT_LEVEL);
  assign wrDmaCfg  = wrStrobe && (effAdr == `OFS_DMACFG);
  assign wrXcfg    = wrStrobe && (effAdr == `OFS_XCFG);
  assign lockOne   = protectLevel != 2'h0;
  assign lockTwo   = protectLevel[1];
  assign lockThree = &protectLevel;

  always_comb begin
    readData = `RESET_WORD;
    mapped   = 1'b1;
    case (effAdr)
      `OFS_CTL0:   readData[`CLOCK_DIVISION_FIELD_LSB +: 2] = clockDivisionField;
      `OFS_CTL1:   readData[`IDLE_LVL_LSB +: 2*`NUM_CH] = idleOutputLevel;
      `OFS_CHMODE: readData = chMode;
      `OFS_CHEN:   readData[4*`NUM_CH-1:0] = chEnable;
      `OFS_PROTECT_LEVEL: begin
        readData[`GATE_BIT]     = primaryOutputGate;
        readData[`AUTO_BIT]     = autoOutputReenable;
        readData[`BRKPOL_BIT]   = breakPolarity;
        readData[`BREAK_INPUTS_ENABLE_BIT]    = breakInputsEnable;
        readData[`ROS_BIT]      = runOffState;
        readData[`IOS_BIT]      = idleOffState;
        readData[`PROTECT_LEVEL_LSB +: 2] = protectLevel;
        readData[`DT_LSB +: 8]   = deadTimeSetting;
      end
      `OFS_DMACFG: begin
        readData[`BCNT_LSB +: 5]   = burstCount;
        readData[`BSTART_LSB +: 5] = burstStartAddress;
      end
      `OFS_XCFG: begin
        readData[`IGNORE_BIT] = redundantWriteIgnore;
        readData[`OUTPUT_VALUE_SELECT_BIT] = outputValueSelect;
      end
      default: begin
        if (cvHit) begin
          readData[15:0] = compareValue[cvIdx];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // ==========================================================
  // Wishbone answer: ack one cycle after the request, unmapped reads zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wbRsp <= '0;
    end else begin
      wbRsp.ack <= reqNew;
      if (reqNew) begin
        wbRsp.dat <= readData;
      end
    end
  end

  // ==========================================================
  // Timer and channel configuration
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clockDivisionField <= 2'h0;
      idleOutputLevel    <= '0;
      chMode             <= '0;
      chEnable           <= '0;
    end else begin
      if (wrCtl0) begin
        clockDivisionField <= merged[`CLOCK_DIVISION_FIELD_LSB +: 2];
      end
      if (wrCtl1 && !lockOne) begin
        idleOutputLevel <= merged[`IDLE_LVL_LSB +: 2*`NUM_CH];
      end
      for (int i = 0; i < `NUM_CH; i++) begin
        if (wrMode && !chEnable[4*i]) begin
          chMode[8*i +: 2] <= merged[8*i +: 2];
        end
        if (wrMode && !(lockThree && chMode[8*i +: 2] == `MODE_OUTPUT)) begin
          chMode[8*i+2 +: 6] <= merged[8*i+2 +: 6];
        end
        if (wrEn) begin
          chEnable[4*i]   <= merged[4*i];
          chEnable[4*i+2] <= merged[4*i+2];
        end
        if (wrEn && !(lockTwo && chMode[8*i +: 2] == `MODE_OUTPUT)) begin
          chEnable[4*i+1] <= merged[4*i+1];
          chEnable[4*i+3] <= merged[4*i+3];
        end
      end
    end
  end

  // Same-value writes are dropped so shadow updates see no fresh write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `NUM_CH; i++) begin
        compareValue[i] <= 16'h0000;
      end
    end else if (wrCv && !(redundantWriteIgnore && merged[15:0] == compareValue[cvIdx])) begin
      compareValue[cvIdx] <= merged[15:0];
    end
  end

  // ==========================================================
  // Protection register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      autoOutputReenable <= 1'b0;
      breakPolarity      <= 1'b0;
      breakInputsEnable  <= 1'b0;
      runOffState        <= 1'b0;
      idleOffState       <= 1'b0;
      protectLevel       <= 2'h0;
      protectWritten     <= 1'b0;
      deadTimeSetting    <= 8'h00;
    end else if (wrProt) begin
      protectWritten <= 1'b1;
      if (!protectWritten) begin
        protectLevel <= merged[`PROTECT_LEVEL_LSB +: 2];
      end
      if (!lockOne) begin
        autoOutputReenable <= merged[`AUTO_BIT];
        breakPolarity      <= merged[`BRKPOL_BIT];
        breakInputsEnable  <= merged[`BREAK_INPUTS_ENABLE_BIT];
        deadTimeSetting    <= merged[`DT_LSB +: 8];
      end
      if (!lockTwo) begin
        runOffState  <= merged[`ROS_BIT];
        idleOffState <= merged[`IOS_BIT];
      end
    end
  end

  // ==========================================================
  // Burst window and extra options
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      burstCount           <= 5'h00;
      burstStartAddress    <= 5'h00;
      burstIndex           <= 5'h00;
      redundantWriteIgnore <= 1'b0;
      outputValueSelect    <= 1'b0;
    end else begin
      if (wrDmaCfg) begin
        burstCount        <= merged[`BCNT_LSB +: 5];
        burstStartAddress <= merged[`BSTART_LSB +: 5];
        burstIndex        <= 5'h00;
      end else if (commit && bufAccess) begin
        burstIndex <= (burstIndex >= burstCount) ? 5'h00 : burstIndex + 5'h01;
      end
      if (wrXcfg) begin
        redundantWriteIgnore <= merged[`IGNORE_BIT];
        outputValueSelect    <= merged[`OUTPUT_VALUE_SELECT_BIT];
      end
    end
  end

  // ==========================================================
  // Break input and primary gate
  logic brkMeta;
  logic brkSync;
  logic monMeta;
  logic monSync;
  logic faultAsync;
  logic faultSync;
  logic gateClear_n;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      brkMeta <= 1'b0;
      brkSync <= 1'b0;
      monMeta <= 1'b0;
      monSync <= 1'b0;
    end else begin
      brkMeta <= breakFaultInput;
      brkSync <= brkMeta;
      monMeta <= clockMonitorFail;
      monSync <= monMeta;
    end
  end

  // Raw path so a fault kills the gate with no clock; a glitch on the pin
  // is therefore enough to drop the gate, which is the safe direction
  assign faultAsync  = breakInputsEnable
                       && ((breakFaultInput == breakPolarity) || clockMonitorFail);
  assign faultSync   = breakInputsEnable && ((brkSync == breakPolarity) || monSync);
  assign gateClear_n = arst_n && !faultAsync;

  always_ff @(posedge ref_clk or negedge gateClear_n) begin
    if (!gateClear_n) begin
      primaryOutputGate <= 1'b0;
    end else if (wrProt) begin
      primaryOutputGate <= merged[`GATE_BIT];
    end else if (updateEvent && autoOutputReenable && !faultSync) begin
      primaryOutputGate <= 1'b1;
    end
  end

  // ==========================================================
  // Dead-time clock and length
  logic [1:0] divCount;
  logic [1:0] divLimit;
  logic       dtTick;
  logic [9:0] dtTicks;

  assign divLimit = (clockDivisionField == 2'h0) ? 2'h0 :
                    (clockDivisionField == 2'h1) ? 2'h1 : 2'h3;
  assign dtTick   = divCount == divLimit;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      divCount <= 2'h0;
    end else begin
      divCount <= dtTick ? 2'h0 : divCount + 2'h1;
    end
  end

  always_comb begin
    dtTicks = {2'h0, deadTimeSetting};
    if (deadTimeSetting[7:6] == 2'b10) begin
      dtTicks = (`DT_BASE_LONG + {4'h0, deadTimeSetting[5:0]}) << 1;
    end else if (deadTimeSetting[7:5] == 3'b110) begin
      dtTicks = (`DT_BASE_SHORT + {5'h00, deadTimeSetting[4:0]}) << 3;
    end else if (deadTimeSetting[7:5] == 3'b111) begin
      dtTicks = (`DT_BASE_SHORT + {5'h00, deadTimeSetting[4:0]}) << 4;
    end
  end

  // ==========================================================
  // Channel output stage
  logic     [`NUM_CH-1:0] dtMain;
  logic     [`NUM_CH-1:0] dtComp;
  ch_pins_t [`NUM_CH-1:0] next_pins;

  for (genvar g = 0; g < `NUM_CH; g++) begin : g_dt
    dead_time_gen u_dead_time (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .tick    (dtTick),
      .refIn   (pwmRef[g]),
      .ticks   (dtTicks),
      .mainAct (dtMain[g]),
      .compAct (dtComp[g])
    );
  end

  always_comb begin
    logic en;
    logic pol;
    logic nen;
    logic npol;
    logic actMain;
    logic actComp;
    en = 1'b0;
    pol = 1'b0;
    nen = 1'b0;
    npol = 1'b0;
    actMain = 1'b0;
    actComp = 1'b0;
    next_pins = '0;
    for (int i = 0; i < `NUM_CH; i++) begin
      en      = chEnable[4*i];
      pol     = chEnable[4*i+1];
      nen     = chEnable[4*i+2];
      npol    = chEnable[4*i+3];
      actMain = (en && nen) ? dtMain[i] : pwmRef[i];
      actComp = (en && nen) ? dtComp[i] : !pwmRef[i];
      if (chMode[8*i +: 2] != `MODE_OUTPUT) begin
        next_pins[i] = '0;
      end else if (primaryOutputGate) begin
        next_pins[i].mainOe  = en || runOffState;
        next_pins[i].mainOut = en ? (actMain ^ pol) : pol;
        next_pins[i].compOe  = nen || runOffState;
        next_pins[i].compOut = nen ? (actComp ^ npol) : npol;
      end else if (idleOffState) begin
        // Output select is not read here or anywhere in the output stage: it has no effect on the pins
        next_pins[i].mainOe  = en;
        next_pins[i].mainOut = idleOutputLevel[2*i];
        next_pins[i].compOe  = nen;
        next_pins[i].compOut = idleOutputLevel[2*i+1];
      end else begin
        next_pins[i] = '0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chPins <= '0;
    end else begin
      chPins <= next_pins;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_gate_fault_clear: assert property (faultSync |-> !primaryOutputGate)
    else $error("gate set while fault active");
  a_gate_auto_set: assert property (updateEvent && autoOutputReenable && !faultSync && !wrProt
    |=> primaryOutputGate || !gateClear_n) else $error("gate not re-enabled on update");
  a_gate_auto_off: assert property (updateEvent && !autoOutputReenable && !primaryOutputGate
    && !wrProt |=> !primaryOutputGate) else $error("gate set without automatic enable");
  a_protect_once: assert property (protectWritten && wrProt |=> $stable(protectLevel))
    else $error("protect level changed twice");
  a_lock_deadtime: assert property (wrProt && lockOne |=> $stable(deadTimeSetting)
    && $stable(breakInputsEnable)) else $error("locked field changed");
  a_burst_wrap: assert property (commit && bufAccess && !wrDmaCfg && burstIndex >= burstCount
    |=> burstIndex == 5'h00) else $error("burst index did not wrap");
  a_burst_step: assert property (commit && bufAccess && !wrDmaCfg && burstIndex < burstCount
    |=> burstIndex == $past(burstIndex) + 5'h01) else $error("burst index did not step");
  a_idle_off: assert property (!primaryOutputGate && !idleOffState ##1 !primaryOutputGate
    |-> !chPins[0].mainOe && !chPins[0].compOe) else $error("idle outputs not disabled");
  a_not_output: assert property (chMode[1:0] != `MODE_OUTPUT |=> !chPins[0].mainOe)
    else $error("input-mode channel driven");
  a_run_off: assert property (primaryOutputGate && chMode[1:0] == `MODE_OUTPUT
    && chEnable[0] == 1'b0 && !runOffState |=> !chPins[0].mainOe)
    else $error("run off-state not disabled");

endmodule : timer_output_ctrl

`default_nettype wire
